// ---- acs_regs.sv ----
// Notes on behaviour
// - Low base keeps address bits 7-0; bits 3-0 read-only; resets to zero.
// - High base keeps address bits 15-8, read/write, resets to zero.
// - Reset clears every support register bit.
// - Sleep status sets on sleep-enable write of one; cleared by writing one.
// - Sleep enable routes sleep status to power-event pin; else ignored.
// - Global lock status sets on lock-release write; cleared by writing one.
// - Global lock enable clear means its status is ignored for the pin.
// - Writing one to BIOS release sets PM1 global lock status.
// - Writing zero to BIOS release changes nothing.
// - SMI command status sets on any SMI command write; write one clears.
// - SMI enable routes SMI status to the pin; else ignored.
// - Mask bit leaves only RTC, wake and timer bits working; others read zero.
// - Mask bit never touches timer bits; they follow the timer clock enable.
// - With timer clock off, timer status and enable read zero, read-only.
`timescale 1ns/100ps
`default_nettype none
module acs_regs (
    // System
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Fixed-register events, same clock
    input wire logic slp_en_write_one,
    input wire logic gl_release_write_one,
    input wire logic smi_cmd_write,
    // Timer clock enable from power control three
    input wire logic pm_timer_clk_en,
    // PM1 event hardware set strobes
    input wire logic [7:0] pm1_evt_set,
    // Outputs
    output logic power_event_req,
    output logic pm1_gbl_sts_set,
    output logic [7:0] pm1_evt_en_view,
    output logic [15:0] gp_status_base,
    output logic irq
);
    logic [7:0] gp_status_base_low_q;
    logic [7:0] gp_status_base_high_q;
    logic [7:0] acpi_support_flags_q;
    logic [7:0] pm1_evt_q;
    logic [7:0] irq_mask_q;
    logic [acs_pkg::NUM_IRQ-1:0] irq_sts;
    logic [2:0] sup_sticky;
    logic acc;
    logic wr;
    logic [7:0] wb;
    logic [7:0] pm1_func;
    logic [7:0] pm1_view;
    logic [7:0] pm1_evt_d;
    logic [acs_pkg::NUM_IRQ-1:0] evt;
    logic pend;

    // Decode a register select from page and offset
    function automatic logic hit(input logic [5:0] a, input logic [1:0] pg,
                                 input logic [3:0] off);
        hit = (a[5:4] == pg) && (a[3:0] == off);
    endfunction

    assign acc = cyc_i && stb_i && !ack_o;
    // Writes land at the edge where the master samples ack high
    assign wr = cyc_i && stb_i && ack_o && we_i && sel_i[0];
    assign wb = dat_i[7:0];
    assign evt = {smi_cmd_write, gl_release_write_one, slp_en_write_one};

    // Functional PM1 event bits under mask and timer clock enable
    always_comb begin
        pm1_func = acs_pkg::PM1_DEFINED;
        if (acpi_support_flags_q[acs_pkg::SUP_PM1_MASK]) begin
            pm1_func = acs_pkg::PM1_MASK_KEEP | acs_pkg::PM1_TMR_BITS;
        end
        if (!pm_timer_clk_en) begin
            pm1_func = pm1_func & ~acs_pkg::PM1_TMR_BITS;
        end
    end
    assign pm1_view = pm1_evt_q & pm1_func;

    // Bus acknowledge: one cycle after request, dropped next cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= acc;
        end
    end

    // Read data
    always_ff @(posedge clk) begin
        if (rst) begin
            dat_o <= '0;
        end else if (acc && !we_i) begin
            dat_o <= '0;
            if (hit(adr_i, acs_pkg::PAGE_MAIN, acs_pkg::ADR_GP_BASE_LOW))
                dat_o[7:0] <= gp_status_base_low_q;
            if (hit(adr_i, acs_pkg::PAGE_MAIN, acs_pkg::ADR_GP_BASE_HIGH))
                dat_o[7:0] <= gp_status_base_high_q;
            if (hit(adr_i, acs_pkg::PAGE_MAIN, acs_pkg::ADR_SUPPORT))
                dat_o[7:0] <= acpi_support_flags_q;
            if (hit(adr_i, acs_pkg::PAGE_MAIN, acs_pkg::ADR_IRQ_STATUS))
                dat_o[acs_pkg::NUM_IRQ-1:0] <= irq_sts;
            if (hit(adr_i, acs_pkg::PAGE_AUX, acs_pkg::ADR_IRQ_MASK))
                dat_o[7:0] <= irq_mask_q;
            if (hit(adr_i, acs_pkg::PAGE_AUX, acs_pkg::ADR_PM1_EVT))
                dat_o[7:0] <= pm1_view;
        end
    end

    // Base address registers
    always_ff @(posedge clk) begin
        if (rst) begin
            gp_status_base_low_q <= acs_pkg::RESET_BYTE;
            gp_status_base_high_q <= acs_pkg::RESET_BYTE;
        end else if (wr) begin
            if (hit(adr_i, acs_pkg::PAGE_MAIN, acs_pkg::ADR_GP_BASE_LOW))
                gp_status_base_low_q <= wb & ~acs_pkg::GP_LOW_RO_MASK;
            if (hit(adr_i, acs_pkg::PAGE_MAIN, acs_pkg::ADR_GP_BASE_HIGH))
                gp_status_base_high_q <= wb;
        end
    end

    // Sticky support flags: sleep, global lock, SMI command
    acs_sticky #(.W(3)) u_sup_sticky (
        .clk(clk),
        .rst(rst),
        .set({smi_cmd_write, gl_release_write_one, slp_en_write_one}),
        .clr({3{wr && hit(adr_i, acs_pkg::PAGE_MAIN, acs_pkg::ADR_SUPPORT)}}
             & {wb[acs_pkg::SUP_SMI_STS], wb[acs_pkg::SUP_GL_STS],
                wb[acs_pkg::SUP_SLP_STS]}),
        .flag_q(sup_sticky)
    );

    // Support register: enables and mask are plain read/write
    always_ff @(posedge clk) begin
        if (rst) begin
            acpi_support_flags_q <= acs_pkg::RESET_BYTE;
        end else begin
            if (wr && hit(adr_i, acs_pkg::PAGE_MAIN, acs_pkg::ADR_SUPPORT)) begin
                acpi_support_flags_q <= (wb & acs_pkg::SUP_RW_MASK)
                    | (acpi_support_flags_q & acs_pkg::SUP_STICKY_MASK);
            end
            acpi_support_flags_q[acs_pkg::SUP_SLP_STS] <= sup_sticky[0];
            acpi_support_flags_q[acs_pkg::SUP_GL_STS] <= sup_sticky[1];
            acpi_support_flags_q[acs_pkg::SUP_SMI_STS] <= sup_sticky[2];
            acpi_support_flags_q[acs_pkg::SUP_BIOS_REL] <= 1'b0;
        end
    end

    // BIOS release: a one pulses global lock status set, zero does nothing
    always_ff @(posedge clk) begin
        if (rst) begin
            pm1_gbl_sts_set <= 1'b0;
        end else begin
            pm1_gbl_sts_set <= wr && wb[acs_pkg::SUP_BIOS_REL]
                && hit(adr_i, acs_pkg::PAGE_MAIN, acs_pkg::ADR_SUPPORT);
        end
    end

    // PM1 event bits: masked write first, then every set is ORed in
    always_comb begin
        pm1_evt_d = pm1_evt_q;
        if (wr && hit(adr_i, acs_pkg::PAGE_AUX, acs_pkg::ADR_PM1_EVT)) begin
            pm1_evt_d = (pm1_evt_q & ~pm1_func) | (wb & pm1_func);
        end
        if (pm1_gbl_sts_set) begin
            pm1_evt_d[acs_pkg::PM1_GBL_STS] = 1'b1;
        end
        pm1_evt_d = pm1_evt_d | (pm1_evt_set & acs_pkg::PM1_DEFINED);
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            pm1_evt_q <= acs_pkg::RESET_BYTE;
        end else begin
            pm1_evt_q <= pm1_evt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pm1_evt_en_view <= acs_pkg::RESET_BYTE;
        end else begin
            pm1_evt_en_view <= pm1_view;
        end
    end

    // Power-event request pin
    always_comb begin
        pend = (sup_sticky[0] && acpi_support_flags_q[acs_pkg::SUP_SLP_EN])
            || (sup_sticky[1] && acpi_support_flags_q[acs_pkg::SUP_GL_EN])
            || (sup_sticky[2] && acpi_support_flags_q[acs_pkg::SUP_SMI_EN]);
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            power_event_req <= 1'b0;
        end else begin
            power_event_req <= pend;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gp_status_base <= '0;
        end else begin
            gp_status_base <= {gp_status_base_high_q, gp_status_base_low_q};
        end
    end

    // Interrupt status, write-one-to-clear, set wins
    acs_sticky #(.W(acs_pkg::NUM_IRQ)) u_irq_sticky (
        .clk(clk),
        .rst(rst),
        .set(evt),
        .clr({acs_pkg::NUM_IRQ{wr
              && hit(adr_i, acs_pkg::PAGE_MAIN, acs_pkg::ADR_IRQ_STATUS)}}
             & wb[acs_pkg::NUM_IRQ-1:0]),
        .flag_q(irq_sts)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_q <= acs_pkg::RESET_BYTE;
        end else if (wr && hit(adr_i, acs_pkg::PAGE_AUX, acs_pkg::ADR_IRQ_MASK)) begin
            irq_mask_q <= wb;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            // A one in the mask blocks that status bit
            irq <= |(irq_sts & ~irq_mask_q[acs_pkg::NUM_IRQ-1:0]);
        end
    end
endmodule
`default_nettype wire

// ---- acs_pkg.sv ----
package acs_pkg;
    // Register byte offsets on the Wishbone bus
    localparam logic [3:0] ADR_GP_BASE_LOW = 4'h0;
    localparam logic [3:0] ADR_GP_BASE_HIGH = 4'h4;
    localparam logic [3:0] ADR_SUPPORT = 4'h8;
    localparam logic [3:0] ADR_IRQ_STATUS = 4'hc;
    localparam logic [3:0] ADR_IRQ_MASK = 4'h0;
    localparam logic [3:0] ADR_PM1_EVT = 4'h4;
    localparam logic [1:0] PAGE_MAIN = 2'h0;
    localparam logic [1:0] PAGE_AUX = 2'h1;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Read-only low bits of the low base register
    localparam logic [7:0] GP_LOW_RO_MASK = 8'h0f;
    // Support register fields
    localparam int SUP_SLP_STS = 0;
    localparam int SUP_SLP_EN = 1;
    localparam int SUP_GL_STS = 2;
    localparam int SUP_GL_EN = 3;
    localparam int SUP_BIOS_REL = 4;
    localparam int SUP_SMI_STS = 5;
    localparam int SUP_SMI_EN = 6;
    localparam int SUP_PM1_MASK = 7;
    // Writable (non-sticky, non-strobe) support bits
    localparam logic [7:0] SUP_RW_MASK = 8'hca;
    // Sticky bits in the support register
    localparam logic [7:0] SUP_STICKY_MASK = 8'h25;
    // PM1 event register view fields
    localparam int PM1_TMR_STS = 0;
    localparam int PM1_TMR_EN = 1;
    localparam int PM1_RTC_STS = 2;
    localparam int PM1_RTC_EN = 3;
    localparam int PM1_WAK_STS = 4;
    localparam int PM1_GBL_STS = 5;
    localparam logic [7:0] PM1_DEFINED = 8'h3f;
    localparam logic [7:0] PM1_MASK_KEEP = 8'h1c;
    localparam logic [7:0] PM1_TMR_BITS = 8'h03;
    // Interrupt status bit positions
    localparam int IRQ_SLP = 0;
    localparam int IRQ_GL = 1;
    localparam int IRQ_SMI = 2;
    localparam int NUM_IRQ = 3;
endpackage

// ---- acs_sticky.sv ----
`timescale 1ns/100ps
`default_nettype none
// Sticky flag: hardware set wins over write-one-to-clear
module acs_sticky #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] flag_q
);
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= '0;
        end else begin
            flag_q <= set | (flag_q & ~clr);
        end
    end
endmodule
`default_nettype wire

// ---- acs_regs_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module acs_regs_monitor (
    // Bus
    input wire logic clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Status side
    input wire logic pm_timer_clk_en,
    input wire logic power_event_req,
    input wire logic pm1_gbl_sts_set,
    input wire logic [7:0] pm1_evt_en_view,
    input wire logic [15:0] gp_status_base,
    input wire logic irq
);
    // Completed write of a one to the BIOS release bit
    wire logic bios_wr = ack_o && we_i && sel_i[0] && dat_i[4]
        && adr_i == 6'h08;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_bios;
        bios_wr;
    endsequence
    a_ack_once: assert property (s_take |=> ack_o ##1 !ack_o)
        else $error("ack not one pulse");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_dat_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_bios_pulse: assert property (s_bios |-> ##[1:2] pm1_gbl_sts_set)
        else $error("no lock status set pulse");
    a_pulse_cause: assert property (pm1_gbl_sts_set |->
        $past(bios_wr) || $past(bios_wr, 2))
        else $error("lock status pulse without cause");
    a_pulse_single: assert property (pm1_gbl_sts_set |=> !pm1_gbl_sts_set)
        else $error("lock status pulse too long");
    a_reset_clear: assert property ($fell(rst) |->
        !power_event_req && !irq && gp_status_base == 16'h0)
        else $error("outputs not clear after reset");
    a_low_ro: assert property (gp_status_base[3:0] == 4'h0)
        else $error("base low bits not zero");
    a_timer_off: assert property ((!pm_timer_clk_en) [*3] |->
        pm1_evt_en_view[1:0] == 2'h0)
        else $error("timer bits live while clock off");
endmodule
bind acs_regs acs_regs_monitor u_mon (.clk(clk), .rst(rst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .pm_timer_clk_en(pm_timer_clk_en),
    .power_event_req(power_event_req), .pm1_gbl_sts_set(pm1_gbl_sts_set),
    .pm1_evt_en_view(pm1_evt_en_view), .gp_status_base(gp_status_base),
    .irq(irq));
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [5:0] a;
        logic [7:0] wd;
        logic [7:0] ex;
    } acs_row_t;
    localparam acs_row_t ROWS [8] = '{
        '{6'h00, 8'hff, 8'hf0}, '{6'h04, 8'ha5, 8'ha5},
        '{6'h08, 8'hca, 8'hca}, '{6'h08, 8'h00, 8'h00},
        '{6'h10, 8'h07, 8'h07}, '{6'h10, 8'h00, 8'h00},
        '{6'h18, 8'hff, 8'h00}, '{6'h20, 8'h5a, 8'h00}};
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic tmr = 1'h0;
    logic [5:0] adr = 6'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [2:0] ev = 3'h0;
    logic [7:0] hs = 8'h00;
    logic [31:0] dat_o;
    logic ack;
    logic per;
    logic gsp;
    logic irq;
    logic [7:0] view;
    logic [15:0] base;
    logic [7:0] rd;
    int failures = 0;
    int n_compared = 0;
    always #50 clk = ~clk;
    acs_regs u_acs_regs (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
        .ack_o(ack), .slp_en_write_one(ev[0]), .gl_release_write_one(ev[1]),
        .smi_cmd_write(ev[2]), .pm_timer_clk_en(tmr), .pm1_evt_set(hs),
        .power_event_req(per), .pm1_gbl_sts_set(gsp),
        .pm1_evt_en_view(view), .gp_status_base(base), .irq(irq));
    task automatic give_verdict;
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        int i;
        i = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat <= {24'h0, d};
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'h1 && i < 20);
        if (ack !== 1'h1) begin
            failures++;
            give_verdict;
        end
        rd = dat_o[7:0];
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] ex);
        wb(1'h0, a, 8'h00);
        chk({24'h0, rd}, {24'h0, ex});
    endtask
    task automatic wrc(input logic [5:0] a, input logic [7:0] d,
                       input logic [7:0] ex);
        wb(1'h1, a, d);
        rdc(a, ex);
    endtask
    task automatic pulse(input logic [2:0] e, input logic [7:0] h);
        ev <= e;
        hs <= h;
        @(posedge clk);
        ev <= 3'h0;
        hs <= 8'h00;
        repeat (2) @(posedge clk);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        foreach (ROWS[i]) begin
            rdc(ROWS[i].a, 8'h00);
        end
        rdc(6'h14, 8'h00);
        chk({29'h0, per, gsp, irq}, 32'h0);
        foreach (ROWS[i]) begin
            wrc(ROWS[i].a, ROWS[i].wd, ROWS[i].ex);
        end
        chk({16'h0, base}, 32'ha5f0);
        wrc(6'h08, 8'h02, 8'h02);
        pulse(3'h1, 8'h00);
        rdc(6'h08, 8'h03);
        rdc(6'h0c, 8'h01);
        chk({30'h0, per, irq}, 32'h3);
        wrc(6'h08, 8'h01, 8'h00);
        wrc(6'h0c, 8'h01, 8'h00);
        chk({30'h0, per, irq}, 32'h0);
        pulse(3'h7, 8'h00);
        rdc(6'h08, 8'h25);
        chk({30'h0, per, irq}, 32'h1);
        wrc(6'h08, 8'h09, 8'h2c);
        chk({31'h0, per}, 32'h1);
        wrc(6'h08, 8'h0c, 8'h28);
        chk({31'h0, per}, 32'h0);
        wrc(6'h08, 8'h40, 8'h60);
        chk({31'h0, per}, 32'h1);
        wrc(6'h10, 8'h07, 8'h07);
        rdc(6'h0c, 8'h07);
        chk({31'h0, irq}, 32'h0);
        wrc(6'h08, 8'h60, 8'h40);
        chk({31'h0, per}, 32'h0);
        wrc(6'h0c, 8'h07, 8'h00);
        wrc(6'h10, 8'h00, 8'h00);
        tmr <= 1'h1;
        wrc(6'h14, 8'h0a, 8'h0a);
        wrc(6'h08, 8'h50, 8'h40);
        rdc(6'h14, 8'h2a);
        wrc(6'h08, 8'h40, 8'h40);
        rdc(6'h14, 8'h2a);
        pulse(3'h0, 8'h15);
        rdc(6'h14, 8'h3f);
        wrc(6'h08, 8'hc0, 8'hc0);
        rdc(6'h14, 8'h1f);
        chk({24'h0, view}, 32'h1f);
        tmr <= 1'h0;
        rdc(6'h14, 8'h1c);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rdc(6'h08, 8'h00);
        chk({16'h0, base}, 32'h0);
        give_verdict;
    end
endmodule
`default_nettype wire
